// file: pkg/rivec_regs.svh
`ifndef RIVEC_REGS_SVH
`define RIVEC_REGS_SVH

// Internal clock cycles the reset line stays active after every source is gone
`define RIVEC_RST_CYC 2048

// Program memory width and vector locations (first byte of each pair)
`define RIVEC_PC_W 12
`define RIVEC_VEC_RESET 12'hffe
`define RIVEC_VEC_SRC0 12'hffc
`define RIVEC_VEC_SRC1 12'hff6
`define RIVEC_VEC_SRC2 12'hff4
`define RIVEC_VEC_SRC3 12'hff2
`define RIVEC_VEC_SRC4 12'hff0

// Field positions in the synchronised pin group
`define RIVEC_PIN_RST_N 0
`define RIVEC_PIN_OSC_OK 1
`define RIVEC_PIN_NMI 2
`define RIVEC_PIN_W 3

// Reset values of the synchronised pin group: pin reset held, no clock, no NMI
`define RIVEC_PIN_INIT 3'h0

`endif

// file: pkg/rivec_pkg.sv
package rivec_pkg;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    RIVEC_ST_RST = 3'h1,
    RIVEC_ST_INIT = 3'h2,
    RIVEC_ST_RUN = 3'h4
  } rivec_state_t;

  // Interrupt source index, 0 is the non-maskable one
  typedef logic [2:0] rivec_src_t;

endpackage

// file: hdl/rivec_sync.sv
`timescale 1ns/100ps
`include "rivec_regs.svh"

module rivec_sync #(
  parameter int W = `RIVEC_PIN_W,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  initial begin
    if (W < 1) $error("rivec_sync: width must be at least 1");
  end

  // A bit changes only once stages two and three agree, which drops one-cycle glitches
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // Stage one feeds stage two only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule // rivec_sync

// file: hdl/rivec_dly.sv
`timescale 1ns/100ps
`include "rivec_regs.svh"

module rivec_dly #(
  parameter int CNT = `RIVEC_RST_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic restart,
  input wire logic run,
  output logic done
);

  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  initial begin
    if (CNT < 2) $error("rivec_dly: count must be at least 2");
  end

  // Restart wins over counting; done holds until the next restart
  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (restart) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (run && !done_q) begin
      cnt_d = cnt_q + CW'(1);
      done_d = (cnt_q == LAST);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule // rivec_dly

// file: hdl/rivec_top.sv
`timescale 1ns/100ps
`include "rivec_regs.svh"

module rivec_top #(
  parameter int RST_CYC = `RIVEC_RST_CYC,
  parameter int EVT_W = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ext_reset_n,
  input wire logic por_detect,
  input wire logic wdog_eoc,
  input wire logic osc_running,
  input wire logic nmi_pin,
  input wire logic global_irq_enable,
  input wire logic [EVT_W-1:0] src1_evt,
  input wire logic [EVT_W-1:0] src2_evt,
  input wire logic [EVT_W-1:0] src3_evt,
  input wire logic [EVT_W-1:0] src4_evt,
  input wire logic [4*EVT_W-1:0] evt_flag_clr,
  input wire logic instr_end,
  input wire logic return_from_interrupt,
  output logic int_reset,
  output logic halt,
  output logic ports_pullup,
  output logic main_osc_off_clr,
  output logic low_freq_aux_osc_sel,
  output logic wdog_reinit,
  output logic stack_clr,
  output logic pc_load,
  output logic [`RIVEC_PC_W-1:0] pc_vec,
  output logic [4:0] irq_ack,
  output logic nmi_mode,
  output logic irq_mode,
  output logic [4*EVT_W-1:0] evt_flags
);

  localparam int PW = `RIVEC_PC_W;

  initial begin
    if (EVT_W < 1) $error("rivec_top: at least one event per source");
  end

  // Vector address of a source, shared by the NMI and maskable paths
  function automatic logic [PW-1:0] vec_of(input rivec_pkg::rivec_src_t s);
    unique case (s)
      3'h0: vec_of = `RIVEC_VEC_SRC0;
      3'h1: vec_of = `RIVEC_VEC_SRC1;
      3'h2: vec_of = `RIVEC_VEC_SRC2;
      3'h3: vec_of = `RIVEC_VEC_SRC3;
      3'h4: vec_of = `RIVEC_VEC_SRC4;
      default: vec_of = `RIVEC_VEC_RESET;
    endcase
  endfunction

  // Pins from outside the clock domain
  logic [`RIVEC_PIN_W-1:0] pin_s;
  rivec_sync #(
    .W(`RIVEC_PIN_W),
    .INIT(`RIVEC_PIN_INIT)
  ) u_sync (
    .clock(clock),
    .nrst(nrst),
    .async_in({nmi_pin, osc_running, ext_reset_n}),
    .sync_out(pin_s)
  );

  logic pin_rst_n, osc_ok, nmi_s;
  assign pin_rst_n = pin_s[`RIVEC_PIN_RST_N];
  assign osc_ok = pin_s[`RIVEC_PIN_OSC_OK];
  assign nmi_s = pin_s[`RIVEC_PIN_NMI];

  // Any source keeps reset active and restarts the delay, whatever the core mode
  logic src_active, dly_run, dly_done;
  assign src_active = !pin_rst_n || por_detect || wdog_eoc;
  assign dly_run = osc_ok;

  rivec_dly #(
    .CNT(RST_CYC)
  ) u_dly (
    .clock(clock),
    .nrst(nrst),
    .restart(src_active),
    .run(dly_run),
    .done(dly_done)
  );

  // Sequencer
  rivec_pkg::rivec_state_t state_q, state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rivec_pkg::RIVEC_ST_RST: begin
        if (dly_done) begin
          state_d = rivec_pkg::RIVEC_ST_INIT;
        end
      end
      rivec_pkg::RIVEC_ST_INIT: state_d = rivec_pkg::RIVEC_ST_RUN;
      rivec_pkg::RIVEC_ST_RUN: state_d = rivec_pkg::RIVEC_ST_RUN;
    endcase
    if (src_active) begin
      state_d = rivec_pkg::RIVEC_ST_RST;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= rivec_pkg::RIVEC_ST_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Event flags: set wins over a clear arriving in the same cycle
  logic [4*EVT_W-1:0] flags_q, flags_d, evt_all;
  assign evt_all = {src4_evt, src3_evt, src2_evt, src1_evt};
  always_comb begin
    flags_d = (flags_q & ~evt_flag_clr) | evt_all;
    if (state_q != rivec_pkg::RIVEC_ST_RUN) begin
      flags_d = '0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Maskable request lines are the OR of their events
  logic [4:1] mreq;
  always_comb begin
    for (int i = 1; i <= 4; i++) begin
      mreq[i] = |flags_q[(i-1)*EVT_W +: EVT_W];
    end
  end

  // NMI edge latch, cleared when its routine starts; a new edge wins
  logic nmi_prev_q, nmi_prev_d, nmi_pend_q, nmi_pend_d;
  logic take_nmi, take_msk;
  assign nmi_prev_d = nmi_s;
  always_comb begin
    nmi_pend_d = nmi_pend_q;
    if (take_nmi) begin
      nmi_pend_d = 1'b0;
    end
    if (nmi_s && !nmi_prev_q) begin
      nmi_pend_d = 1'b1;
    end
    if (state_q != rivec_pkg::RIVEC_ST_RUN) begin
      nmi_pend_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_prev_d;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  // Modes after a return in this cycle; the return unwinds the innermost level
  logic nmi_eff, irq_eff;
  logic nmi_mode_q, nmi_mode_d, irq_mode_q, irq_mode_d;
  always_comb begin
    nmi_eff = nmi_mode_q;
    irq_eff = irq_mode_q;
    if (return_from_interrupt) begin
      if (nmi_mode_q) begin
        nmi_eff = 1'b0;
      end else begin
        irq_eff = 1'b0;
      end
    end
  end

  // Arbitration at instruction end only; so a pending request right after
  // the closing return is taken at once, otherwise execution continues
  logic run_now;
  rivec_pkg::rivec_src_t msk_src;
  assign run_now = (state_q == rivec_pkg::RIVEC_ST_RUN) && !src_active;
  assign take_nmi = run_now && instr_end && nmi_pend_q && !nmi_eff;
  assign take_msk = run_now && instr_end && !take_nmi && !nmi_eff && !irq_eff
    && global_irq_enable && (|mreq);
  always_comb begin
    msk_src = 3'h4;
    for (int i = 4; i >= 1; i--) begin
      if (mreq[i]) begin
        msk_src = 3'(i);
      end
    end
  end

  always_comb begin
    nmi_mode_d = nmi_eff;
    irq_mode_d = irq_eff;
    if (take_nmi) begin
      nmi_mode_d = 1'b1;
    end
    if (take_msk) begin
      irq_mode_d = 1'b1;
    end
    if (state_q == rivec_pkg::RIVEC_ST_INIT) begin
      nmi_mode_d = 1'b1;
      irq_mode_d = 1'b0;
    end
    if (state_d == rivec_pkg::RIVEC_ST_RST) begin
      nmi_mode_d = 1'b0;
      irq_mode_d = 1'b0;
    end
  end

  // Core-facing strobes and vector, all registered
  logic stack_clr_q, stack_clr_d, pc_load_q, pc_load_d;
  logic [PW-1:0] pc_vec_q, pc_vec_d;
  logic [4:0] ack_q, ack_d;
  always_comb begin
    stack_clr_d = 1'b0;
    pc_load_d = 1'b0;
    pc_vec_d = pc_vec_q;
    ack_d = '0;
    if (state_q == rivec_pkg::RIVEC_ST_INIT && !src_active) begin
      stack_clr_d = 1'b1;
      pc_load_d = 1'b1;
      pc_vec_d = `RIVEC_VEC_RESET;
    end else if (take_nmi) begin
      pc_load_d = 1'b1;
      pc_vec_d = vec_of(3'h0);
      ack_d[0] = 1'b1;
    end else if (take_msk) begin
      pc_load_d = 1'b1;
      pc_vec_d = vec_of(msk_src);
      ack_d[msk_src] = 1'b1;
    end
  end

  // Reset side effects last for the whole reset state, aux oscillator select only while osc_ok is low; a clock is the only way out
  logic rst_d, aux_d;
  logic rst_q, aux_q;
  assign rst_d = (state_d == rivec_pkg::RIVEC_ST_RST);
  assign aux_d = rst_d && !osc_ok;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nmi_mode_q <= 1'b0;
      irq_mode_q <= 1'b0;
      stack_clr_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_vec_q <= `RIVEC_VEC_RESET;
      ack_q <= '0;
      rst_q <= 1'b1;
      aux_q <= 1'b1;
    end else begin
      nmi_mode_q <= nmi_mode_d;
      irq_mode_q <= irq_mode_d;
      stack_clr_q <= stack_clr_d;
      pc_load_q <= pc_load_d;
      pc_vec_q <= pc_vec_d;
      ack_q <= ack_d;
      rst_q <= rst_d;
      aux_q <= aux_d;
    end
  end

  assign int_reset = rst_q;
  assign halt = rst_q;
  assign ports_pullup = rst_q;
  assign main_osc_off_clr = rst_q;
  assign wdog_reinit = rst_q;
  assign low_freq_aux_osc_sel = aux_q;
  assign stack_clr = stack_clr_q;
  assign pc_load = pc_load_q;
  assign pc_vec = pc_vec_q;
  assign irq_ack = ack_q;
  assign nmi_mode = nmi_mode_q;
  assign irq_mode = irq_mode_q;
  assign evt_flags = flags_q;

  // Helper: delay-enabled cycles seen in the reset state
  logic [15:0] h_cnt_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      h_cnt_q <= '0;
    end else if (src_active) begin
      h_cnt_q <= '0;
    end else if (dly_run && !dly_done) begin
      h_cnt_q <= h_cnt_q + 16'h0001;
    end
  end

  sequence s_leave_reset;
    state_q == rivec_pkg::RIVEC_ST_RST ##1 state_q == rivec_pkg::RIVEC_ST_INIT;
  endsequence

  sequence s_init_done;
    pc_load_q && stack_clr_q && nmi_mode_q && pc_vec_q == `RIVEC_VEC_RESET;
  endsequence

  a_src_resets: assert property (@(posedge clock) disable iff (!nrst)
    src_active |=> int_reset && halt && ports_pullup && wdog_reinit)
    else $error("Reset source did not assert internal reset");

  a_delay_len: assert property (@(posedge clock) disable iff (!nrst)
    s_leave_reset |-> $past(h_cnt_q) == 16'(RST_CYC))
    else $error("Internal reset released after wrong cycle count");

  a_init_seq: assert property (@(posedge clock) disable iff (!nrst)
    s_leave_reset ##0 !src_active |=> s_init_done ##0 !int_reset)
    else $error("Initialization did not load reset vector");

  a_no_early: assert property (@(posedge clock) disable iff (!nrst)
    !dly_done && state_q == rivec_pkg::RIVEC_ST_RST |=> state_q == rivec_pkg::RIVEC_ST_RST)
    else $error("Left reset before delay expired");

  a_nmi_vec: assert property (@(posedge clock) disable iff (!nrst)
    irq_ack[0] |-> pc_load && pc_vec == `RIVEC_VEC_SRC0 && nmi_mode)
    else $error("NMI entry wrong vector or mode");

  a_msk_prio: assert property (@(posedge clock) disable iff (!nrst)
    take_msk && mreq[1] |=> irq_ack[1] && pc_vec == `RIVEC_VEC_SRC1)
    else $error("Source one not granted first");

  a_no_nest: assert property (@(posedge clock) disable iff (!nrst)
    irq_mode_q && !return_from_interrupt |-> !take_msk)
    else $error("Maskable interrupt nested");

  a_gen_mask: assert property (@(posedge clock) disable iff (!nrst)
    !global_irq_enable |=> irq_ack[4:1] == 4'h0)
    else $error("Maskable taken while disabled");

  a_return_from_interrupt_mode: assert property (@(posedge clock) disable iff (!nrst)
    run_now && return_from_interrupt && nmi_mode_q && !take_nmi |=> !nmi_mode_q)
    else $error("Return did not leave NMI mode");

endmodule // rivec_top

// file: tb/rivec_core_model.sv
`timescale 1ns/100ps

module rivec_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic int_reset,
  input wire logic ret_req,
  output logic instr_end,
  output logic return_from_interrupt
);
  logic [1:0] ph_q;
  logic ret_q;

  // Four-cycle instructions; nothing executes while the core is held in reset
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 2'h0;
      ret_q <= 1'b0;
      instr_end <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      instr_end <= #10 (ph_q == 2'h3) && !int_reset;
      return_from_interrupt <= #10 (ph_q == 2'h3) && !int_reset && (ret_q || ret_req);
      // A return waits for the end of the running instruction
      if (ph_q == 2'h3 && !int_reset) begin
        ret_q <= 1'b0;
      end else if (ret_req) begin
        ret_q <= 1'b1;
      end
    end
  end
endmodule // rivec_core_model

// file: tb/rivec_tb_top.sv
`timescale 1ns/100ps
`include "rivec_regs.svh"

module rivec_tb_top;
  localparam int RST_CYC = 16;
  localparam int EVT_W = 4;
  logic clock = 1'b0;
  logic nrst, ext_reset_n, por_detect, wdog_eoc, osc_running, nmi_pin, global_irq_enable;
  logic instr_end, return_from_interrupt, ret_req, int_reset, halt, ports_pullup;
  logic main_osc_off_clr, low_freq_aux_osc_sel, wdog_reinit, stack_clr, pc_load;
  logic nmi_mode, irq_mode;
  logic [4*EVT_W-1:0] evts, evt_flag_clr, evt_flags;
  logic [`RIVEC_PC_W-1:0] pc_vec;
  logic [4:0] irq_ack;
  logic [11:0] vec_tbl [5] = '{`RIVEC_VEC_SRC0, `RIVEC_VEC_SRC1, `RIVEC_VEC_SRC2,
    `RIVEC_VEC_SRC3, `RIVEC_VEC_SRC4};
  int n_fail = 0;
  int n_checks = 0;
  int n_cyc = 0;

  // 10 MHz clock
  always #50 clock = ~clock;

  rivec_top #(.RST_CYC(RST_CYC), .EVT_W(EVT_W)) DUT (
    .clock(clock), .nrst(nrst), .ext_reset_n(ext_reset_n), .por_detect(por_detect),
    .wdog_eoc(wdog_eoc), .osc_running(osc_running), .nmi_pin(nmi_pin),
    .global_irq_enable(global_irq_enable), .src1_evt(evts[EVT_W-1:0]),
    .src2_evt(evts[2*EVT_W-1:EVT_W]), .src3_evt(evts[3*EVT_W-1:2*EVT_W]),
    .src4_evt(evts[4*EVT_W-1:3*EVT_W]), .evt_flag_clr(evt_flag_clr),
    .instr_end(instr_end), .return_from_interrupt(return_from_interrupt),
    .int_reset(int_reset), .halt(halt), .ports_pullup(ports_pullup),
    .main_osc_off_clr(main_osc_off_clr), .low_freq_aux_osc_sel(low_freq_aux_osc_sel),
    .wdog_reinit(wdog_reinit), .stack_clr(stack_clr), .pc_load(pc_load), .pc_vec(pc_vec),
    .irq_ack(irq_ack), .nmi_mode(nmi_mode), .irq_mode(irq_mode), .evt_flags(evt_flags)
  );

  rivec_core_model core (
    .clock(clock), .nrst(nrst), .int_reset(int_reset), .ret_req(ret_req),
    .instr_end(instr_end), .return_from_interrupt(return_from_interrupt)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under 1000 cycles
  always @(posedge clock) begin
    n_cyc = n_cyc + 1;
    if (n_cyc == 4000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  // Inputs always move 10 ns after the edge, outputs are read there too
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      #10;
    end
  endtask

  task automatic reset_outs(input logic v);
    chk("int_reset", v, int_reset);
    chk("halt", v, halt);
    chk("pullup", v, ports_pullup);
    chk("osc_off_clr", v, main_osc_off_clr);
    chk("wdog_reinit", v, wdog_reinit);
  endtask

  task automatic no_load(input int n);
    repeat (n) begin
      chk("no load", 0, pc_load);
      step(1);
    end
  endtask

  task automatic ret();
    ret_req = 1'b1;
    step(1);
    ret_req = 1'b0;
  endtask

  task automatic wait_ack(input logic [4:0] ack, input logic [11:0] vec);
    int k;
    k = 0;
    while (pc_load !== 1'b1 && k < 12) begin
      step(1);
      k++;
    end
    chk("ack", {7'h0, ack}, {7'h0, irq_ack});
    chk("vector", vec, pc_vec);
    step(1);
  endtask

  // Release the pin and count cycles until the internal reset falls;
  // it drops as the sequencer enters the init cycle, one edge before the load
  task automatic boot();
    int k;
    k = 0;
    ext_reset_n = 1'b1;
    osc_running = 1'b1;
    while (int_reset === 1'b1 && k < RST_CYC + 20) begin
      chk("early load", 0, pc_load);
      step(1);
      k++;
    end
    chk("delay", 1, (k > RST_CYC) && (k < RST_CYC + 9));
    step(1);
    chk("load", 1, pc_load);
    chk("reset vec", `RIVEC_VEC_RESET, pc_vec);
    chk("stack clr", 1, stack_clr);
    step(1);
    chk("nmi mode", 1, nmi_mode);
    reset_outs(0);
  endtask

  task automatic t_pin();
    step(8);
    reset_outs(1);
    ext_reset_n = 1'b1;
    step(8);
    ext_reset_n = 1'b0; // Short low pulse mid-count must restart the delay
    step(4);
    boot();
  endtask

  task automatic t_irq();
    global_irq_enable = 1'b1;
    evts = '1;
    step(1);
    evts = '0;
    chk("flags", 1, evt_flags === '1);
    no_load(8);
    ret();
    for (int s = 1; s <= 4; s++) begin
      wait_ack(5'h01 << s, vec_tbl[s]);
      chk("irq mode", 1, irq_mode);
      no_load(8);
      evt_flag_clr[s*EVT_W-1 -: EVT_W] = '1;
      step(1);
      evt_flag_clr = '0;
      ret();
    end
    step(6);
    chk("irq mode", 0, irq_mode);
    no_load(8);
  endtask

  task automatic t_nmi();
    global_irq_enable = 1'b0;
    evts[EVT_W] = 1'b1;
    step(1);
    evts = '0;
    no_load(8);
    global_irq_enable = 1'b1;
    wait_ack(5'h04, vec_tbl[2]);
    nmi_pin = 1'b1;
    wait_ack(5'h01, vec_tbl[0]);
    chk("nmi mode", 1, nmi_mode);
    nmi_pin = 1'b0;
    ret();
    step(6);
    chk("nmi mode", 0, nmi_mode);
    chk("irq mode", 1, irq_mode);
    evt_flag_clr = '1;
    step(1);
    evt_flag_clr = '0;
    ret();
    step(6);
    chk("irq mode", 0, irq_mode);
  endtask

  task automatic t_wdog();
    wdog_eoc = 1'b1;
    step(2);
    reset_outs(1);
    wdog_eoc = 1'b0;
    boot();
    ext_reset_n = 1'b0; // Pin reset taken from run mode
    step(5);
    reset_outs(1);
    boot();
  endtask

  task automatic t_por();
    osc_running = 1'b0;
    por_detect = 1'b1;
    step(5);
    chk("aux osc", 1, low_freq_aux_osc_sel);
    reset_outs(1);
    por_detect = 1'b0;
    repeat (RST_CYC + 8) begin
      chk("held", 1, int_reset);
      step(1);
    end
    boot();
    chk("aux osc", 0, low_freq_aux_osc_sel);
  endtask

  // Main sequence: power-up with the pin low, then one scenario after another
  initial begin
    nrst = 1'b0;
    ext_reset_n = 1'b0;
    por_detect = 1'b0;
    wdog_eoc = 1'b0;
    osc_running = 1'b1;
    nmi_pin = 1'b0;
    global_irq_enable = 1'b0;
    evts = '0;
    evt_flag_clr = '0;
    ret_req = 1'b0;
    repeat (6) @(posedge clock);
    #10;
    nrst = 1'b1;
    t_pin();
    t_irq();
    t_nmi();
    t_wdog();
    t_por();
    conclude();
  end
endmodule // rivec_tb_top
